// ---- pkg/startup_seq_map.svh ----
`ifndef STARTUP_SEQ_MAP_SVH
`define STARTUP_SEQ_MAP_SVH
// phase selector encodings: 0..6 are phases, then done-driven, keep/no-wait
`define SEL_WIDTH            4
`define SEL_DONE             4'h7
`define SEL_KEEP             4'h8
`define SEL_SKIP_LOCK_WAIT           4'h8
// reset defaults of the option selectors
`define DEF_SET_RESET_PHASE  4'h6
`define DEF_WRITE_EN_PHASE   4'h6
`define DEF_TRISTATE_PHASE   4'h5
`define DEF_DONE_PHASE       4'h4
`define DEF_LOCK_PHASE       4'h8
// phase counter
`define PHASE_WIDTH          3
`define PHASE_LAST           3'h7
`define PHASE_FINAL          3'h6
// security tiers
`define SEC_NONE             2'h0
`define SEC_TIER_ONE         2'h1
`define SEC_TIER_TWO         2'h2
// user revision code and debug stream figures
`define REV_CODE_WIDTH       32
`define DEBUG_ZERO_WORD      32'h0000_0000
`define CRC_WIDTH            32
`define CRC_POLY             32'h04c1_1db7
`define CRC_SEED             32'hffff_ffff
`endif

// ---- pkg/startup_seq_pkg.sv ----
`include "startup_seq_map.svh"
package startup_seq_pkg;
  // sequencer options, all static after configuration load
  typedef struct packed {
    logic [3:0] set_reset_release_phase;
    logic [3:0] write_enable_phase;
    logic [3:0] tristate_release_phase;
    logic [3:0] lock_wait_phase;
    logic [3:0] done_phase;
    logic       done_pipeline_option;
    logic       done_active_drive;
    logic       persist;
    logic [1:0] security;
    logic [1:0] startup_clk_sel;
  } seq_cfg_type;

  // global control outputs
  typedef struct packed {
    logic global_set_reset;
    logic global_write_enable;
    logic block_memory_enable;
    logic global_io_tristate;
  } glob_ctl_type;

  typedef enum logic [1:0] {
    CLK_CONFIG = 2'h0,
    CLK_FABRIC = 2'h1,
    CLK_TEST   = 2'h2
  } clk_sel_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_type;
endpackage

// ---- logic/startup_clk_select.sv ----
`timescale 1ns/10ps
`default_nettype none
// turns the chosen startup clock source into a one-cycle step enable
module startup_clk_select (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       config_clk_i,
  input  wire logic       fabric_startup_clock_i,
  input  wire logic       test_clk_i,
  output logic            step_o
);
  logic src;
  logic prev;
  logic next_prev;
  logic next_step;
  logic step;

  // source mux; unknown codes fall back to the configuration clock
  always_comb begin
    case (startup_seq_pkg::clk_sel_type'(sel_i))
      startup_seq_pkg::CLK_FABRIC: src = fabric_startup_clock_i;
      startup_seq_pkg::CLK_TEST:   src = test_clk_i;
      default:                     src = config_clk_i;
    endcase
    next_prev = src;
    next_step = src & ~prev; // rising edge only
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 1'b0;
      step <= 1'b0;
    end else begin
      prev <= next_prev;
      step <= next_step;
    end
  end

  assign step_o = step;
endmodule
`default_nettype wire

// ---- logic/frame_crc_check.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "startup_seq_map.svh"
// per-frame crc check for debug streams, one data bit per valid cycle
module frame_crc_check #(
  parameter int WIDTH = `CRC_WIDTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             bit_valid_i,
  input  wire logic             bit_i,
  input  wire logic             frame_end_i,
  input  wire logic [WIDTH-1:0] expected_i,
  output logic                  check_o,
  output logic                  error_o
);
  logic [WIDTH-1:0] crc;
  logic [WIDTH-1:0] next_crc;
  logic             check;
  logic             next_check;
  logic             err;
  logic             next_err;

  // serial crc; reseeded at every frame end so errors localise to one frame
  always_comb begin
    next_crc   = crc;
    next_check = 1'b0;
    next_err   = 1'b0;
    if (bit_valid_i) begin
      next_crc = {crc[WIDTH-2:0], 1'b0} ^ ((crc[WIDTH-1] ^ bit_i) ? `CRC_POLY : '0);
    end
    if (frame_end_i) begin
      next_check = 1'b1;
      next_err   = (crc != expected_i);
      next_crc   = `CRC_SEED;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc   <= `CRC_SEED;
      check <= 1'b0;
      err   <= 1'b0;
    end else begin
      crc   <= next_crc;
      check <= next_check;
      err   <= next_err;
    end
  end

  assign check_o = check;
  assign error_o = err;
endmodule
`default_nettype wire

// ---- logic/config_startup_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "startup_seq_map.svh"
// Summary of operation
// - set/reset released at phase 1..6, on done feedback, or kept; default 6.
// - done-selected events fire once done feedback is high.
// - keep setting never changes a control that could lose data.
// - write enable and block memory enable asserted at chosen phase, default 6.
// - block memory reads and writes stay blocked until write-enable phase.
// - keep setting holds write enable at its current value.
// - io tristate released at phase 1..6, on done, or kept; default 5.
// - stall at chosen phase 0..6 until all locks report; default no wait.
// - done output activates at phase 1..6, default 4; delayed when pipelined.
// - with pipelining, wait for done pin high then two startup edges.
// - active drive pushes done pin high instead of pull-up only.
// - tier one blocks readback; tier two also blocks partial reconfiguration.
// - persistence keeps configuration port pins reserved after startup.
// - 32-bit user revision code loaded from the bitstream.
// - debug mode checks crc after every frame to locate errors.
// - startup clock is configuration, fabric or test clock; default configuration.
module config_startup_sequencer #(
  parameter int LOCK_COUNT = 4,
  parameter int COL_WIDTH  = 16
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        config_loaded_i,
  input  wire startup_seq_pkg::seq_cfg_type cfg_i,
  input  wire logic                        config_clk_i,
  input  wire logic                        fabric_startup_clock_i,
  input  wire logic                        test_clk_i,
  input  wire logic [LOCK_COUNT-1:0]       lock_i,
  input  wire logic                        done_pin_i,
  input  wire logic                        rev_code_load_i,
  input  wire logic [`REV_CODE_WIDTH-1:0]  rev_code_i,
  input  wire logic                        debug_mode_i,
  input  wire logic                        dbg_write_i,
  input  wire logic [31:0]                 dbg_data_i,
  input  wire logic                        crc_bit_valid_i,
  input  wire logic                        crc_bit_i,
  input  wire logic                        frame_end_i,
  input  wire logic [`CRC_WIDTH-1:0]       frame_crc_i,
  input  wire logic                        readback_req_i,
  input  wire logic                        partial_req_i,
  output logic                             done_pin_o,
  output logic                             done_pin_oe_o,
  output startup_seq_pkg::glob_ctl_type    glob_o,
  output logic [`PHASE_WIDTH-1:0]          phase_o,
  output logic                             seq_done_o,
  output logic                             readback_allow_o,
  output logic                             partial_allow_o,
  output logic                             port_reserved_o,
  output logic [`REV_CODE_WIDTH-1:0]       user_revision_code_o,
  output logic [31:0]                      debug_output_register_o,
  output logic [COL_WIDTH-1:0]             frame_count_o,
  output logic                             frame_crc_error_o,
  output logic [COL_WIDTH-1:0]             error_frame_o
);
  // ==========================================================
  // startup clock and crc helpers
  // ==========================================================
  logic step;
  logic crc_check;
  logic crc_error;

  startup_clk_select u_clk_sel (
    .core_clk_i             (core_clk_i),
    .arst_n_i               (arst_n_i),
    .sel_i                  (cfg_i.startup_clk_sel),
    .config_clk_i           (config_clk_i),
    .fabric_startup_clock_i (fabric_startup_clock_i),
    .test_clk_i             (test_clk_i),
    .step_o                 (step)
  );

  frame_crc_check #(
    .WIDTH (`CRC_WIDTH)
  ) u_crc (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .bit_valid_i (crc_bit_valid_i & debug_mode_i),
    .bit_i       (crc_bit_i),
    .frame_end_i (frame_end_i & debug_mode_i),
    .expected_i  (frame_crc_i),
    .check_o     (crc_check),
    .error_o     (crc_error)
  );

  // ==========================================================
  // phase sequencer
  // ==========================================================
  startup_seq_pkg::seq_state_type state;
  startup_seq_pkg::seq_state_type next_state;
  logic [`PHASE_WIDTH-1:0]        phase;
  logic [`PHASE_WIDTH-1:0]        next_phase;
  logic                           done_pipe;
  logic                           next_done_pipe;
  logic                           done_feedback;
  logic                           all_locked;
  logic                           lock_stall;
  logic                           done_stall;
  logic                           seq_done;
  logic                           next_seq_done;

  // pipelined copy of the pin; only moves on a startup edge
  assign done_feedback = cfg_i.done_pipeline_option ? done_pipe : done_pin_i;
  assign all_locked    = &lock_i;
  // no-wait encoding is excluded by value, since its low bits would match phase 0
  assign lock_stall    = (cfg_i.lock_wait_phase != `SEL_SKIP_LOCK_WAIT) &&
                         (cfg_i.lock_wait_phase[`PHASE_WIDTH-1:0] == phase) && !all_locked;
  // the last phase waits for the shared line before entering done
  assign done_stall    = (phase == `PHASE_FINAL) && !done_feedback;

  always_comb begin
    next_state     = state;
    next_phase     = phase;
    next_done_pipe = done_pipe;
    if (step) begin
      next_done_pipe = done_pin_i;
    end
    case (state)
      startup_seq_pkg::SEQ_IDLE: begin
        if (config_loaded_i) begin
          next_state = startup_seq_pkg::SEQ_RUN;
          next_phase = '0;
        end
      end
      startup_seq_pkg::SEQ_RUN: begin
        if (step && !lock_stall) begin
          if (phase == `PHASE_FINAL) begin
            if (!done_stall) begin
              next_state = startup_seq_pkg::SEQ_DONE;
            end
          end else begin
            next_phase = phase + 3'h1;
          end
        end
      end
      startup_seq_pkg::SEQ_DONE: begin
        next_state = startup_seq_pkg::SEQ_DONE;
      end
      default: begin
        next_state = startup_seq_pkg::SEQ_IDLE;
      end
    endcase
    // registered so the status output comes straight from a flop
    next_seq_done = (next_state == startup_seq_pkg::SEQ_DONE);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state     <= startup_seq_pkg::SEQ_IDLE;
      phase     <= '0;
      done_pipe <= 1'b0;
      seq_done  <= 1'b0;
    end else begin
      state     <= next_state;
      phase     <= next_phase;
      done_pipe <= next_done_pipe;
      seq_done  <= next_seq_done;
    end
  end

  // ==========================================================
  // global controls
  // ==========================================================
  function automatic logic reached(input logic [3:0] sel,
                                   input logic [`PHASE_WIDTH-1:0] ph,
                                   input logic running,
                                   input logic fb);
    logic r;
    r = 1'b0;
    if (sel == `SEL_DONE) begin
      r = running & fb;
    end else if (sel <= 4'h6) begin
      r = running & (ph >= sel[`PHASE_WIDTH-1:0]);
    end
    return r;
  endfunction

  startup_seq_pkg::glob_ctl_type glob;
  startup_seq_pkg::glob_ctl_type next_glob;
  logic                          active;
  logic                          done_out;
  logic                          next_done_out;

  // phases count as reached once out of idle and the phase register is at or past them
  assign active = (state != startup_seq_pkg::SEQ_IDLE);

  always_comb begin
    next_glob     = glob;
    next_done_out = done_out;
    // keep leaves the present value untouched so no data is disturbed
    if (cfg_i.set_reset_release_phase != `SEL_KEEP &&
        reached(cfg_i.set_reset_release_phase, phase, active, done_feedback)) begin
      next_glob.global_set_reset = 1'b0;
    end
    if (cfg_i.write_enable_phase != `SEL_KEEP) begin
      if (reached(cfg_i.write_enable_phase, phase, active, done_feedback)) begin
        next_glob.global_write_enable = 1'b1;
        next_glob.block_memory_enable = 1'b1;
      end
    end
    if (cfg_i.tristate_release_phase != `SEL_KEEP &&
        reached(cfg_i.tristate_release_phase, phase, active, done_feedback)) begin
      next_glob.global_io_tristate = 1'b0;
    end
    // pipelined chains hold done back until one more startup edge after its phase
    if (active && cfg_i.done_phase != 4'h0 && phase >= cfg_i.done_phase[`PHASE_WIDTH-1:0] &&
        (step || !cfg_i.done_pipeline_option)) begin
      next_done_out = 1'b1;
    end
  end

  // reset state: everything held, keep options then simply never change it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      glob     <= '{global_set_reset: 1'b1, global_write_enable: 1'b0,
                    block_memory_enable: 1'b0, global_io_tristate: 1'b1};
      done_out <= 1'b0;
    end else begin
      glob     <= next_glob;
      done_out <= next_done_out;
    end
  end

  // ==========================================================
  // done pin, security, persistence, revision code
  // ==========================================================
  logic                        pin_val;
  logic                        pin_oe;
  logic                        rb_allow;
  logic                        pr_allow;
  logic                        reserved;
  logic [`REV_CODE_WIDTH-1:0]  rev;
  logic                        next_pin_val;
  logic                        next_pin_oe;
  logic                        next_rb_allow;
  logic                        next_pr_allow;
  logic                        next_reserved;
  logic [`REV_CODE_WIDTH-1:0]  next_rev;

  // open drain: pull low until done; drive high only when asked to
  always_comb begin
    next_pin_val  = done_out & cfg_i.done_active_drive;
    next_pin_oe   = !done_out | cfg_i.done_active_drive;
    next_rb_allow = (cfg_i.security == `SEC_NONE) && readback_req_i;
    next_pr_allow = (cfg_i.security != `SEC_TIER_TWO) && partial_req_i;
    // pins stay reserved until done unless persistence holds them afterwards
    next_reserved = (state != startup_seq_pkg::SEQ_DONE) | cfg_i.persist;
    next_rev      = rev_code_load_i ? rev_code_i : rev;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_val  <= 1'b0;
      pin_oe   <= 1'b1;
      rb_allow <= 1'b0;
      pr_allow <= 1'b0;
      reserved <= 1'b1;
      rev      <= '0;
    end else begin
      pin_val  <= next_pin_val;
      pin_oe   <= next_pin_oe;
      rb_allow <= next_rb_allow;
      pr_allow <= next_pr_allow;
      reserved <= next_reserved;
      rev      <= next_rev;
    end
  end

  // ==========================================================
  // debug output register and frame tracking
  // ==========================================================
  logic [31:0]          dbg_reg;
  logic [COL_WIDTH-1:0] frames;
  logic                 frame_err;
  logic [COL_WIDTH-1:0] err_frame;
  logic [31:0]          next_dbg_reg;
  logic [COL_WIDTH-1:0] next_frames;
  logic                 next_frame_err;
  logic [COL_WIDTH-1:0] next_err_frame;

  // the stream writes zeros then column numbers; we only store them
  always_comb begin
    next_dbg_reg   = dbg_write_i ? dbg_data_i : dbg_reg;
    next_frames    = frames;
    next_frame_err = frame_err;
    next_err_frame = err_frame;
    if (crc_check) begin
      next_frames = frames + 1'b1;
      // first failing frame is latched so later frames cannot hide it
      if (crc_error && !frame_err) begin
        next_frame_err = 1'b1;
        next_err_frame = frames;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_reg   <= `DEBUG_ZERO_WORD;
      frames    <= '0;
      frame_err <= 1'b0;
      err_frame <= '0;
    end else begin
      dbg_reg   <= next_dbg_reg;
      frames    <= next_frames;
      frame_err <= next_frame_err;
      err_frame <= next_err_frame;
    end
  end

  assign done_pin_o              = pin_val;
  assign done_pin_oe_o           = pin_oe;
  assign glob_o                  = glob;
  assign phase_o                 = phase;
  assign seq_done_o              = seq_done;
  assign readback_allow_o        = rb_allow;
  assign partial_allow_o         = pr_allow;
  assign port_reserved_o         = reserved;
  assign user_revision_code_o    = rev;
  assign debug_output_register_o = dbg_reg;
  assign frame_count_o           = frames;
  assign frame_crc_error_o       = frame_err;
  assign error_frame_o           = err_frame;
endmodule
`default_nettype wire

// ---- testbench/config_startup_sequencer_props.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "startup_seq_map.svh"
// ====================
// startup sequencer checker
module config_startup_sequencer_props #(
  parameter int LOCK_COUNT = 4
) (
  input wire logic                          core_clk_i,
  input wire logic                          arst_n_i,
  input wire startup_seq_pkg::seq_cfg_type  cfg_i,
  input wire logic [LOCK_COUNT-1:0]         lock_i,
  input wire logic                          rev_code_load_i,
  input wire logic [`REV_CODE_WIDTH-1:0]    rev_code_i,
  input wire logic                          done_pin_o,
  input wire logic                          done_pin_oe_o,
  input wire startup_seq_pkg::glob_ctl_type glob_o,
  input wire logic [`PHASE_WIDTH-1:0]       phase_o,
  input wire logic                          seq_done_o,
  input wire logic                          readback_allow_o,
  input wire logic                          partial_allow_o,
  input wire logic [`REV_CODE_WIDTH-1:0]    user_revision_code_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // parked at the lock phase with a loop still unlocked
  sequence s_lock_miss;
    cfg_i.lock_wait_phase < 4'h7 && phase_o == cfg_i.lock_wait_phase[2:0] && !(&lock_i);
  endsequence
  // the final step needs phase six to have been reached first
  sequence s_done_rise;
    $rose(seq_done_o);
  endsequence
  a_lock_stall: assert property (s_lock_miss |=> phase_o == $past(phase_o))
    else $error("phase moved past an unlocked lock phase");
  a_phase_step: assert property (phase_o != $past(phase_o) |-> phase_o == $past(phase_o) + 3'h1)
    else $error("phase skipped or went back");
  a_phase_limit: assert property (phase_o <= `PHASE_FINAL)
    else $error("phase beyond the last one");
  a_done_final: assert property (s_done_rise |-> phase_o == `PHASE_FINAL)
    else $error("done before the last phase");
  a_we_early: assert property (cfg_i.write_enable_phase inside {[4'h1:4'h6]}
    && phase_o < cfg_i.write_enable_phase[2:0] |-> !glob_o.global_write_enable)
    else $error("write enable before its phase");
  a_we_keep: assert property (cfg_i.write_enable_phase == `SEL_KEEP |-> !glob_o.global_write_enable)
    else $error("kept write enable changed");
  a_bme_we: assert property (glob_o.block_memory_enable == glob_o.global_write_enable)
    else $error("block memory enable apart from write enable");
  a_tri_keep: assert property (cfg_i.tristate_release_phase == `SEL_KEEP |-> glob_o.global_io_tristate)
    else $error("kept tristate released");
  a_drive_done: assert property (seq_done_o && cfg_i.done_active_drive |-> done_pin_oe_o && done_pin_o)
    else $error("done not driven high");
  a_sec_read: assert property (cfg_i.security != `SEC_NONE |=> !readback_allow_o)
    else $error("readback let through under security");
  a_sec_part: assert property (cfg_i.security == `SEC_TIER_TWO |=> !partial_allow_o)
    else $error("partial reconfiguration let through");
  a_rev_load: assert property (rev_code_load_i |=> user_revision_code_o == $past(rev_code_i))
    else $error("revision code not stored");
endmodule
bind config_startup_sequencer config_startup_sequencer_props #(.LOCK_COUNT(LOCK_COUNT)) props_u (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg_i), .lock_i(lock_i),
  .rev_code_load_i(rev_code_load_i), .rev_code_i(rev_code_i), .done_pin_o(done_pin_o),
  .done_pin_oe_o(done_pin_oe_o), .glob_o(glob_o), .phase_o(phase_o), .seq_done_o(seq_done_o),
  .readback_allow_o(readback_allow_o), .partial_allow_o(partial_allow_o),
  .user_revision_code_o(user_revision_code_o));
`default_nettype wire

// ---- testbench/done_line_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ====================
// other device on the shared open-drain done line
module done_line_partner (
  input  wire logic release_i,
  input  wire logic dut_val_i,
  input  wire logic dut_oe_i,
  output logic      line_o
);
  // wired-and with pull-up: a device not yet done holds the line low
  assign line_o = release_i & ~(dut_oe_i & ~dut_val_i);
endmodule
`default_nettype wire

// ---- testbench/config_startup_sequencer_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "startup_seq_map.svh"
// ====================
// bench top
module config_startup_sequencer_tb_top;
  logic core_clk = 1'b0, arst_n = 1'b0, loaded = 1'b0, rel = 1'b0, line;
  logic [2:0] sclk = 3'h0;
  logic [3:0] lock = 4'hf;
  logic rev_load = 1'b0, dbg_mode = 1'b0, dbg_wr = 1'b0, fe = 1'b0, rb_req = 1'b0, pr_req = 1'b0;
  logic crc_bv = 1'b0, crc_b = 1'b0;
  logic [31:0] rev = 32'h0, dbg_data = 32'h0, fcrc = `CRC_SEED;
  logic done_val, done_oe, seq_done, rb_ok, pr_ok, reserved, crc_err;
  logic [2:0] phase;
  logic [31:0] rev_o, dbg_o;
  logic [15:0] fcount, eframe;
  startup_seq_pkg::seq_cfg_type c;
  startup_seq_pkg::seq_cfg_type cfg = '0;
  startup_seq_pkg::glob_ctl_type glob;
  int bad_count = 0, compares = 0, n;

  // 8 ns period; the bench drives 1 ns after each rising edge
  always #4 core_clk = ~core_clk;

  config_startup_sequencer dut_u (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .config_loaded_i(loaded), .cfg_i(cfg),
    .config_clk_i(sclk[0]), .fabric_startup_clock_i(sclk[1]), .test_clk_i(sclk[2]),
    .lock_i(lock), .done_pin_i(line), .rev_code_load_i(rev_load), .rev_code_i(rev),
    .debug_mode_i(dbg_mode), .dbg_write_i(dbg_wr), .dbg_data_i(dbg_data), .crc_bit_valid_i(crc_bv),
    .crc_bit_i(crc_b), .frame_end_i(fe), .frame_crc_i(fcrc), .readback_req_i(rb_req),
    .partial_req_i(pr_req), .done_pin_o(done_val), .done_pin_oe_o(done_oe), .glob_o(glob),
    .phase_o(phase), .seq_done_o(seq_done), .readback_allow_o(rb_ok), .partial_allow_o(pr_ok),
    .port_reserved_o(reserved), .user_revision_code_o(rev_o), .debug_output_register_o(dbg_o),
    .frame_count_o(fcount), .frame_crc_error_o(crc_err), .error_frame_o(eframe));
  done_line_partner partner_u (.release_i(rel), .dut_val_i(done_val), .dut_oe_i(done_oe), .line_o(line));

  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // one edge of the chosen slow clock, slow enough for the sampler
  task automatic edge_step;
    sclk[cfg.startup_clk_sel] = 1'b1;
    cyc(4);
    sclk = 3'h0;
    cyc(4);
  endtask
  // reset with new options; a step while idle must be ignored
  task automatic start(input startup_seq_pkg::seq_cfg_type s);
    arst_n = 1'b0;
    loaded = 1'b0;
    cfg = s;
    cyc(2);
    arst_n = 1'b1;
    edge_step();
    check(phase, 3'h0);
    loaded = 1'b1;
    cyc(2);
  endtask
  // bounded wait for the done state, counting the steps it took
  task automatic finish_seq(output int k);
    k = 0;
    while (seq_done !== 1'b1 && k < 4) begin
      edge_step();
      k++;
    end
    if (seq_done !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no done state", $time);
      results();
    end
  endtask

  // ====================
  // tests
  initial begin
    c = '{4'h6, 4'h6, 4'h5, 4'h8, 4'h4, 1'b0, 1'b0, 1'b0, `SEC_NONE, 2'h0};
    start(c);
    for (int k = 1; k <= 6; k++) begin
      edge_step();
      check(phase, k[2:0]);
      check(glob.global_io_tristate, k < 5);
      check(glob.global_write_enable, k >= 6);
      check(glob.block_memory_enable, k >= 6);
      check(glob.global_set_reset, k < 6);
      check(done_oe, k < 4);
    end
    edge_step();
    edge_step();
    check(seq_done, 1'b0);
    rel = 1'b1;
    finish_seq(n);
    check(n, 1);
    check(reserved, 1'b0);
    rb_req = 1'b1;
    pr_req = 1'b1;
    cyc(2);
    check({rb_ok, pr_ok}, 2'b11);
    $display("test 1 defaults done");
    c = '{`SEL_DONE, 4'h6, `SEL_KEEP, 4'h2, 4'h3, 1'b0, 1'b1, 1'b1, `SEC_TIER_ONE, 2'h1};
    lock = 4'h0;
    start(c);
    repeat (4) edge_step();
    check(phase, 3'h2);
    lock = 4'hf;
    repeat (4) edge_step();
    check(phase, 3'h6);
    check(glob.global_set_reset, 1'b0);
    check(glob.global_io_tristate, 1'b1);
    check({done_oe, done_val}, 2'b11);
    finish_seq(n);
    check(reserved, 1'b1);
    check({rb_ok, pr_ok}, 2'b01);
    rev = 32'h5a3c_9e01;
    rev_load = 1'b1;
    cyc(1);
    rev_load = 1'b0;
    cyc(1);
    check(rev_o, 32'h5a3c_9e01);
    dbg_mode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      dbg_data = i ? 32'h0000_002a : `DEBUG_ZERO_WORD;
      dbg_wr = 1'b1;
      cyc(1);
      dbg_wr = 1'b0;
      cyc(1);
      check(dbg_o, dbg_data);
    end
    for (int f = 0; f < 2; f++) begin
      crc_bv = (f == 0);
      crc_b = 1'b1;
      cyc(1);
      crc_bv = 1'b0;
      // one set bit shifted into the seed leaves all ones but the lowest bit
      fcrc = f ? (`CRC_SEED ^ 32'h1) : 32'hffff_fffe;
      fe = 1'b1;
      cyc(1);
      fe = 1'b0;
      cyc(2);
    end
    check(fcount, 16'h2);
    check(crc_err, 1'b1);
    check(eframe, 16'h1);
    $display("test 2 lock, keep, drive done");
    c = '{4'h6, `SEL_KEEP, 4'h5, 4'h8, 4'h4, 1'b1, 1'b0, 1'b0, `SEC_TIER_TWO, 2'h2};
    rel = 1'b0;
    start(c);
    repeat (4) edge_step();
    check(done_oe, 1'b1);
    repeat (2) edge_step();
    check(done_oe, 1'b0);
    check(glob.global_write_enable, 1'b0);
    check(glob.block_memory_enable, 1'b0);
    check({rb_ok, pr_ok}, 2'b00);
    rel = 1'b1;
    finish_seq(n);
    check(n, 2);
    $display("test 3 pipelined done");
    results();
  end
endmodule
`default_nettype wire
